// *** core/mabs_defines.svh ***
// constants for the auto buffer and status stack block
// assumes a 20 MHz system clock and 16-bit words numbered msb-first
`ifndef MABS_DEFINES_SVH
`define MABS_DEFINES_SVH
// control block word offsets of the four pointer words
`define MABS_OFF_IBP 16'h0004
`define MABS_OFF_OBP 16'h0005
`define MABS_OFF_LIB 16'h0006
`define MABS_OFF_LOB 16'h0007
// status word bit positions, msb-first bit n sits at index 15-n
`define MABS_ST_RTI 15
`define MABS_ST_OVF 14
`define MABS_ST_IN 13
`define MABS_ST_OUT 12
`define MABS_ST_ID_HI 11
`define MABS_ST_ID_LO 5
// status word reset value
`define MABS_STATUS_RST 16'h0000
// queue capacity and data buffer depth
`define MABS_QDEPTH 40
`define MABS_FIFO_DEPTH 32
// real-time tick period
`define MABS_CLK_NS 50
`define MABS_TICK_MS 10
`define MABS_TICK_CYCLES ((`MABS_TICK_MS * 1000000) / `MABS_CLK_NS)
`endif

// *** core/mabs_pkg.sv ***
// types shared by the auto buffer and status stack block
// assumes nothing beyond the defines header
package mabs_pkg;
    // control block size select: 32, 16 or 8 words per port
    typedef enum logic [1:0] {
        MABS_BLK_32 = 2'h0,
        MABS_BLK_16 = 2'h1,
        MABS_BLK_8 = 2'h2
    } mabs_blk_t;
    // engine states, gray coded along the service path
    typedef enum logic [2:0] {
        MABS_IDLE = 3'h0,
        MABS_RD_PTR = 3'h1,
        MABS_RD_END = 3'h3,
        MABS_WR_PTR = 3'h2,
        MABS_XFER = 3'h6,
        MABS_FINISH = 3'h7
    } mabs_state_t;
endpackage

// *** core/mabs_top.sv ***
// auto input/output byte buffering engine and interrupt status stack
// assumes memory answers each access with a one-cycle mem_ack, host pulses are one cycle
//
// Overview of operation
// - pointers used only for auto mode ports
// - bump input pointer before storing each byte
// - pointer upper 15 bits word, bit 15 half
// - selector 0 upper half, 1 lower half
// - pointer past end: first byte ends buffer
// - byte stored at end address raises input-done
// - bump output pointer, then fetch selected half
// - output pointer marks last byte sent
// - byte fetched at end raises output-done
// - end below pointer plus one: one byte
// - status queue holds forty entries
// - start pulse removes oldest queue entry
// - entries remain: done stays, interrupt again
// - empty queue reads zeros in bits 2-3
// - enabled clock ticks every 10 ms, bit 0
// - status read clears real-time bit 0
// - tick may share word with port events
// - bit 1 flags queue overflow past forty
// - bits 2/3 input/output done, 11-15 zero
// - port identity from control word address bits
// - pop to empty clears the done flag unless real-time bit 0 stays set
// - start after overflow empties whole queue
`timescale 1ns/1ps
`include "mabs_defines.svh"

// data buffer with registered ready toward the source
module mabs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = `MABS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready_q,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire push = in_valid & in_ready_q;
    wire pop = out_valid & out_ready;

    // occupancy and read side
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign cnt_d = cnt_q + CW'(push) - CW'(pop);

    // pointer advance with wrap at the configured depth
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers, count and ready
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready_q <= 1'b0;
        end else begin
            if (push) wr_q <= nxt(wr_q);
            if (pop) rd_q <= nxt(rd_q);
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d < CW'(DEPTH));
        end
    end
endmodule

module mabs_top #(
    parameter int TICK_CYCLES = `MABS_TICK_CYCLES,
    parameter int QDEPTH = `MABS_QDEPTH,
    parameter int FIFO_DEPTH = `MABS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] pcb_base,
    input wire mabs_pkg::mabs_blk_t block_size,
    input wire logic rtc_enable,
    input wire logic host_status_read,
    input wire logic host_start,
    output logic [15:0] status_word_q,
    output logic done_q,
    output logic irq_req_q,
    input wire logic rx_valid,
    output logic rx_ready_q,
    input wire logic [6:0] rx_port,
    input wire logic [7:0] rx_byte,
    input wire logic rx_auto,
    input wire logic tx_req,
    input wire logic [6:0] tx_port,
    input wire logic tx_auto,
    output logic tx_ready_q,
    output logic tx_valid_q,
    output logic [7:0] tx_byte_q,
    output logic [6:0] tx_port_q,
    output logic mem_req_q,
    output logic mem_we_q,
    output logic [14:0] mem_addr_q,
    output logic [1:0] mem_be_q,
    output logic [15:0] mem_wdata_q,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata
);
    import mabs_pkg::*;

    localparam int QAW = $clog2(QDEPTH);
    localparam int QCW = $clog2(QDEPTH + 1);

    // control word address of a port: base plus port times block size plus offset
    function automatic logic [15:0] cw_addr(input logic [15:0] base, input mabs_blk_t sz,
                                            input logic [6:0] port, input logic [15:0] off);
        logic [15:0] p;
        p = {9'h000, port};
        case (sz)
            MABS_BLK_16: cw_addr = base + (p << 4) + off;
            MABS_BLK_8: cw_addr = base + (p << 3) + off;
            default: cw_addr = base + (p << 5) + off;
        endcase
    endfunction

    // port identity taken back out of a control word address
    function automatic logic [6:0] cw_id(input logic [15:0] a, input mabs_blk_t sz);
        case (sz)
            MABS_BLK_16: cw_id = a[10:4];
            MABS_BLK_8: cw_id = a[9:3];
            default: cw_id = a[11:5];
        endcase
    endfunction

    // receive data buffer
    logic fifo_valid;
    logic fifo_pop;
    logic [15:0] fifo_data;
    mabs_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(rx_valid),
        .in_ready_q(rx_ready_q),
        .in_data({rx_auto, rx_port, rx_byte}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // engine registers
    mabs_state_t state_q, state_d;
    logic is_tx_q;
    logic [6:0] port_q;
    logic [7:0] byte_q;
    logic [15:0] ptr_q, end_q;
    logic [15:0] ptr_d;
    logic fin_q;
    logic tx_pend_q;
    logic [6:0] tx_pend_port_q;

    // transmit request latch, requests on non-auto ports are ignored
    wire tx_take = tx_req & tx_ready_q & tx_auto;
    wire start_tx = (state_q == MABS_IDLE) & tx_pend_q;
    wire start_rx = (state_q == MABS_IDLE) & ~tx_pend_q & fifo_valid;
    wire rx_is_auto = fifo_data[15];
    assign fifo_pop = start_rx;

    // service sequence: read pointer, read end, write bumped pointer, move byte
    wire ack = mem_req_q & mem_ack;
    wire [15:0] ptr_inc = ptr_q + 16'h0001;
    // end reached, or pointer already at or past end on the first byte
    wire fin_now = (ptr_inc == end_q) | (ptr_q >= end_q);
    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        case (state_q)
            MABS_IDLE: begin
                if (start_tx) state_d = MABS_RD_PTR;
                else if (start_rx && rx_is_auto) state_d = MABS_RD_PTR;
            end
            MABS_RD_PTR: begin
                if (ack) begin
                    state_d = MABS_RD_END;
                    ptr_d = mem_rdata;
                end
            end
            MABS_RD_END: begin
                if (ack) state_d = MABS_WR_PTR;
            end
            MABS_WR_PTR: begin
                if (ack) begin
                    state_d = MABS_XFER;
                    ptr_d = ptr_inc;
                end
            end
            MABS_XFER: begin
                if (ack) state_d = MABS_FINISH;
            end
            MABS_FINISH: state_d = MABS_IDLE;
            default: state_d = MABS_IDLE;
        endcase
    end

    // next port and direction as seen by the address decode
    wire nx_tx = (state_q == MABS_IDLE) ? start_tx : is_tx_q;
    wire [6:0] nx_port = (state_q == MABS_IDLE) ?
                         (start_tx ? tx_pend_port_q : fifo_data[14:8]) : port_q;
    wire [7:0] nx_byte = (state_q == MABS_IDLE) ? fifo_data[7:0] : byte_q;
    wire [15:0] off_ptr = nx_tx ? `MABS_OFF_OBP : `MABS_OFF_IBP;
    wire [15:0] off_end = nx_tx ? `MABS_OFF_LOB : `MABS_OFF_LIB;

    // memory request decode for the state being entered
    wire nx_mem = (state_d == MABS_RD_PTR) | (state_d == MABS_RD_END) |
                  (state_d == MABS_WR_PTR) | (state_d == MABS_XFER);
    wire [15:0] a_ptr = cw_addr(pcb_base, block_size, nx_port, off_ptr);
    wire [15:0] a_end = cw_addr(pcb_base, block_size, nx_port, off_end);
    // upper 15 bits select the word, bit 15 (lsb) the half
    wire [14:0] a_data = ptr_d[15:1];
    wire sel_lo = ptr_d[0];
    wire [14:0] addr_d = (state_d == MABS_RD_PTR) ? a_ptr[14:0] :
                         (state_d == MABS_RD_END) ? a_end[14:0] :
                         (state_d == MABS_WR_PTR) ? a_ptr[14:0] : a_data;
    wire we_d = (state_d == MABS_WR_PTR) | ((state_d == MABS_XFER) & ~nx_tx);
    // selector 0 is the upper (left) byte, 1 the lower (right) byte
    wire [1:0] be_d = ((state_d == MABS_XFER) && !nx_tx) ?
                      (sel_lo ? 2'h1 : 2'h2) : 2'h3;
    // reads drive zero so the write data holds still while a fetch waits
    wire [15:0] wdata_d = (state_d == MABS_WR_PTR) ? ptr_inc :
                          (we_d ? {nx_byte, nx_byte} : 16'h0000);
    wire [7:0] tx_pick = ptr_q[0] ? mem_rdata[7:0] : mem_rdata[15:8];

    // engine state and captured words
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= MABS_IDLE;
            is_tx_q <= 1'b0;
            port_q <= 7'h00;
            byte_q <= 8'h00;
            ptr_q <= 16'h0000;
            end_q <= 16'h0000;
            fin_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            if (state_q == MABS_IDLE) begin
                is_tx_q <= nx_tx;
                port_q <= nx_port;
                byte_q <= nx_byte;
            end
            if (state_q == MABS_RD_END && ack) end_q <= mem_rdata;
            if (state_q == MABS_WR_PTR && ack) fin_q <= fin_now;
        end
    end

    // memory port registers
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 15'h0000;
            mem_be_q <= 2'h0;
            mem_wdata_q <= 16'h0000;
        end else begin
            mem_req_q <= nx_mem;
            mem_we_q <= nx_mem & we_d;
            mem_addr_q <= addr_d;
            mem_be_q <= be_d;
            mem_wdata_q <= wdata_d;
        end
    end

    // transmit side: pending request and byte out
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_pend_q <= 1'b0;
            tx_pend_port_q <= 7'h00;
            tx_ready_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_byte_q <= 8'h00;
            tx_port_q <= 7'h00;
        end else begin
            if (tx_take) begin
                tx_pend_q <= 1'b1;
                tx_pend_port_q <= tx_port;
            end else if (start_tx) begin
                tx_pend_q <= 1'b0;
            end
            tx_ready_q <= ~(tx_pend_q | tx_take) & ~(is_tx_q & (state_q != MABS_IDLE));
            tx_valid_q <= is_tx_q & (state_q == MABS_XFER) & ack;
            if (is_tx_q && state_q == MABS_XFER && ack) begin
                tx_byte_q <= tx_pick;
                tx_port_q <= port_q;
            end
        end
    end

    // status queue: entries are {input done, output done, port identity}
    logic [8:0] q_mem [QDEPTH];
    logic [QAW-1:0] q_wr_q, q_rd_q;
    logic [QCW-1:0] q_cnt_q;
    logic ovf_q, rti_q;
    logic [31:0] tick_cnt_q;
    wire [15:0] fin_addr = cw_addr(pcb_base, block_size, port_q, 16'h0000);
    wire ev_push = (state_q == MABS_FINISH) & fin_q;
    wire [8:0] ev_word = {~is_tx_q, is_tx_q, cw_id(fin_addr, block_size)};
    wire q_full = (q_cnt_q == QCW'(QDEPTH));
    wire q_empty = (q_cnt_q == '0);
    // a start after overflow flushes everything, else removes the oldest entry
    wire q_flush = host_start & ovf_q;
    wire q_pop = host_start & ~ovf_q & ~q_empty;
    wire q_push = ev_push & (~q_full | q_pop) & ~ovf_q;
    wire ovf_set = ev_push & q_full & ~q_pop & ~ovf_q;
    wire tick = rtc_enable & (tick_cnt_q == 32'(TICK_CYCLES - 1));

    // queue pointer step with wrap
    function automatic logic [QAW-1:0] qnxt(input logic [QAW-1:0] p);
        qnxt = (p == QAW'(QDEPTH - 1)) ? '0 : p + QAW'(1);
    endfunction

    // next counts after this cycle's push, pop and flush
    wire [QAW-1:0] q_rd_d = q_flush ? q_wr_q : (q_pop ? qnxt(q_rd_q) : q_rd_q);
    wire [QCW-1:0] q_cnt_base = q_flush ? '0 : (q_cnt_q - QCW'(q_pop));
    wire [QCW-1:0] q_cnt_d = q_cnt_base + QCW'(q_push | (ev_push & q_flush));
    wire ovf_d = ovf_set | (ovf_q & ~q_flush);
    // a tick arriving with the read sets the bit again
    wire rti_d = tick | (rti_q & ~host_status_read);
    wire done_d = rti_d | ovf_d | (q_cnt_d != '0);

    // status word as presented to a read; empty queue gives zero event bits
    wire [8:0] head = q_mem[q_rd_q];
    wire [15:0] st_now = {rti_q, ovf_q, head[8] & ~q_empty, head[7] & ~q_empty,
                          head[6:0], 5'h00};

    // queue storage, a push during a flush lands at the new head
    always_ff @(posedge clk) begin
        if (q_push || (ev_push && q_flush)) begin
            q_mem[q_wr_q] <= ev_word;
        end
    end

    // queue pointers, flags and tick counter
    always_ff @(posedge clk) begin
        if (rst) begin
            q_wr_q <= '0;
            q_rd_q <= '0;
            q_cnt_q <= '0;
            ovf_q <= 1'b0;
            rti_q <= 1'b0;
            tick_cnt_q <= 32'h00000000;
        end else begin
            if (q_push || (ev_push && q_flush)) q_wr_q <= qnxt(q_wr_q);
            q_rd_q <= q_rd_d;
            q_cnt_q <= q_cnt_d;
            ovf_q <= ovf_d;
            rti_q <= rti_d;
            if (!rtc_enable || tick) tick_cnt_q <= 32'h00000000;
            else tick_cnt_q <= tick_cnt_q + 32'h00000001;
        end
    end

    // host facing outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            status_word_q <= `MABS_STATUS_RST;
            done_q <= 1'b0;
            irq_req_q <= 1'b0;
        end else begin
            if (host_status_read) status_word_q <= st_now;
            done_q <= done_d;
            irq_req_q <= tick | q_push | ovf_set | (host_start & done_d);
        end
    end
endmodule

// *** test/mabs_top_sva.sv ***
// port assertions for the auto buffer engine and status stack
// assumes binding onto mabs_top, one clock, synchronous reset
`timescale 1ns/1ps
module mabs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_start,
    input wire logic host_status_read,
    input wire logic [15:0] status_word_q,
    input wire logic done_q,
    input wire logic irq_req_q,
    input wire logic tx_valid_q,
    input wire logic mem_req_q,
    input wire logic mem_we_q,
    input wire logic [14:0] mem_addr_q,
    input wire logic [1:0] mem_be_q,
    input wire logic [15:0] mem_wdata_q,
    input wire logic mem_ack
);
    logic after_ptr_q;
    logic [15:0] ptr_q;
    // pointer write-back and the data access right behind it
    wire ptr_wr = mem_req_q && mem_we_q && mem_be_q == 2'h3;
    wire data_acc = mem_req_q && after_ptr_q && !ptr_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // remember whether the last completed access wrote a pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            after_ptr_q <= 1'b0;
        end else if (mem_req_q && mem_ack) begin
            after_ptr_q <= ptr_wr;
        end
    end
    // keep the written pointer value
    always_ff @(posedge clk) begin
        if (ptr_wr && mem_ack) begin
            ptr_q <= mem_wdata_q;
        end
    end
    req_hold_a: assert property (mem_req_q && !mem_ack |=> mem_req_q
        && $stable(mem_addr_q) && $stable(mem_we_q) && $stable(mem_wdata_q))
        else $error("memory access changed before ack");
    byte_order_a: assert property (mem_req_q && mem_we_q && !ptr_wr |-> after_ptr_q)
        else $error("byte stored without pointer update");
    word_addr_a: assert property (data_acc |-> mem_addr_q == ptr_q[15:1])
        else $error("data word address not from pointer");
    byte_lane_a: assert property (data_acc && mem_we_q
        |-> mem_be_q == (ptr_q[0] ? 2'h1 : 2'h2)) else $error("byte in wrong half");
    fetch_src_a: assert property (tx_valid_q
        |-> $past(data_acc) && $past(mem_ack) && !$past(mem_we_q)) else $error("no fetch");
    status_tail_a: assert property (status_word_q[4:0] == 5'h00)
        else $error("status tail bits not zero");
    done_fall_a: assert property ($fell(done_q)
        |-> $past(host_start) || $past(host_status_read)) else $error("done dropped alone");
    pop_irq_a: assert property (host_start ##1 done_q |-> irq_req_q)
        else $error("no interrupt after pop with entries left");
endmodule

bind mabs_top mabs_chk u_chk (.clk(clk), .rst(rst), .host_start(host_start),
    .host_status_read(host_status_read), .status_word_q(status_word_q), .done_q(done_q),
    .irq_req_q(irq_req_q), .tx_valid_q(tx_valid_q), .mem_req_q(mem_req_q),
    .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_be_q(mem_be_q),
    .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack));

// *** test/mabs_mem.sv ***
// word memory answering the engine's accesses, 1024 words
// assumes one access at a time with byte lanes as in mem_be_q
`timescale 1ns/1ps
module mabs_mem (
    input wire logic clk,
    input wire logic slow,
    input wire logic req,
    input wire logic we,
    input wire logic [14:0] addr,
    input wire logic [1:0] be,
    input wire logic [15:0] wdata,
    output logic ack,
    output logic [15:0] rdata
);
    logic [15:0] ram [0:1023];
    int m_seed = 7;
    initial ack = 1'b0;
    initial rdata = 16'h0000;
    // ack once per access, stalling at random when slow; data bus churns when idle
    always @(posedge clk) begin
        if (req && !ack && (!slow || $random(m_seed) % 3 == 0)) begin
            ack <= 1'b1;
            rdata <= ram[addr[9:0]];
            if (we && be[1]) ram[addr[9:0]][15:8] <= wdata[15:8];
            if (we && be[0]) ram[addr[9:0]][7:0] <= wdata[7:0];
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
        end
    end
endmodule

// *** test/mabs_top_test.sv ***
// self-checking bench for the auto buffer engine and status stack
// assumes mabs_mem as memory and the checker bound in its own file
`timescale 1ns/1ps
module mabs_top_test;
    import mabs_pkg::*;
    localparam int TICKS = 20;
    logic clk = 1'b0, rst = 1'b1, rtc_enable = 1'b0, host_status_read = 1'b0;
    logic host_start = 1'b0, rx_valid = 1'b0, rx_auto = 1'b0, tx_req = 1'b0;
    logic tx_auto = 1'b0, slow = 1'b0, rd_pend = 1'b0;
    logic [6:0] rx_port = 7'h00, tx_port = 7'h00, tx_port_q;
    logic [7:0] rx_byte = 8'h00, tx_byte_q;
    mabs_blk_t block_size = MABS_BLK_32;
    logic done_q, irq_req_q, rx_ready_q, tx_ready_q, tx_valid_q, mem_req_q, mem_we_q, mem_ack;
    logic [15:0] status_word_q, mem_wdata_q, mem_rdata, w;
    logic [14:0] mem_addr_q;
    logic [1:0] mem_be_q;
    logic [7:0] bs [0:44];
    logic [31:0] st_e;
    logic [31:0] exp_st [$];
    logic [15:0] exp_tx [$];
    int failures = 0, n_compared = 0, seed = 26, refused = 0, n = 0;
    always #25 clk = ~clk;
    mabs_top #(.TICK_CYCLES(TICKS)) dut (.clk(clk), .rst(rst), .pcb_base(16'h0100),
        .block_size(block_size), .rtc_enable(rtc_enable), .host_status_read(host_status_read),
        .host_start(host_start), .status_word_q(status_word_q), .done_q(done_q),
        .irq_req_q(irq_req_q), .rx_valid(rx_valid), .rx_ready_q(rx_ready_q), .rx_port(rx_port),
        .rx_byte(rx_byte), .rx_auto(rx_auto), .tx_req(tx_req), .tx_port(tx_port),
        .tx_auto(tx_auto), .tx_ready_q(tx_ready_q), .tx_valid_q(tx_valid_q),
        .tx_byte_q(tx_byte_q), .tx_port_q(tx_port_q), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
        .mem_addr_q(mem_addr_q), .mem_be_q(mem_be_q), .mem_wdata_q(mem_wdata_q),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    mabs_mem mem (.clk(clk), .slow(slow), .req(mem_req_q), .we(mem_we_q), .addr(mem_addr_q),
        .be(mem_be_q), .wdata(mem_wdata_q), .ack(mem_ack), .rdata(mem_rdata));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // wait until the engine has been quiet for six cycles
    task automatic settle();
        int idle;
        idle = 0;
        for (int i = 0; i < 3000 && idle < 6; i++) begin
            @(negedge clk);
            idle = (mem_req_q || !rx_ready_q || !tx_ready_q) ? 0 : idle + 1;
        end
        if (idle < 6) begin
            failures++;
            conclude();
        end
    endtask
    // offer a byte from a posedge and hold it until taken
    task automatic rx(input logic [6:0] p, input logic [7:0] b, input logic au);
        rx_valid <= 1'b1;
        rx_port <= p;
        rx_byte <= b;
        rx_auto <= au;
        for (int i = 0; i <= 400; i++) begin
            @(posedge clk);
            if (rx_ready_q) break;
            refused++;
            if (i == 400) begin
                failures++;
                conclude();
            end
        end
    endtask
    task automatic tx(input logic [6:0] p, input logic au, input logic [7:0] b);
        @(posedge clk);
        tx_req <= 1'b1;
        tx_port <= p;
        tx_auto <= au;
        if (au) exp_tx.push_back({1'b0, p, b});
        @(posedge clk);
        tx_req <= 1'b0;
        settle();
    endtask
    task automatic host(input logic rd, input logic st, input logic [15:0] m,
                        input logic [15:0] v);
        @(posedge clk);
        if (rd) exp_st.push_back({m, v});
        host_status_read <= rd;
        host_start <= st;
        @(posedge clk);
        host_status_read <= 1'b0;
        host_start <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pcb(input logic [9:0] a, input logic [15:0] p, input logic [15:0] e);
        mem.ram[a] = p;
        mem.ram[a + 10'h002] = e;
    endtask
    // score fetched bytes and status reads against the oldest note
    always @(posedge clk) begin
        rd_pend <= host_status_read;
        if (tx_valid_q) begin
            if (exp_tx.size() == 0) check(16'h0001, 16'h0000);
            else check({1'b0, tx_port_q, tx_byte_q}, exp_tx.pop_front());
        end
        if (rd_pend) begin
            st_e = exp_st.pop_front();
            check(status_word_q & st_e[31:16], st_e[15:0]);
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        pcb(10'h124, 16'h03FF, 16'h0402);
        pcb(10'h165, 16'h05FF, 16'h0601);
        pcb(10'h185, 16'h0601, 16'h0600);
        mem.ram[10'h300] = 16'hA1B2;
        mem.ram[10'h301] = 16'hC3D4;
        for (int i = 0; i < 3; i++) begin
            bs[i] = 8'($random(seed));
            @(posedge clk);
            rx(7'h01, bs[i], 1'b1);
            rx_valid <= 1'b0;
            settle();
        end
        check(mem.ram[10'h124], 16'h0402);
        check(mem.ram[10'h200], {bs[0], bs[1]});
        check(mem.ram[10'h201] & 16'hFF00, {bs[2], 8'h00});
        tx(7'h03, 1'b1, 8'hA1);
        tx(7'h03, 1'b1, 8'hB2);
        tx(7'h04, 1'b1, 8'hC3);
        tx(7'h03, 1'b0, 8'h00);
        check(16'(exp_tx.size()), 16'h0000);
        check(mem.ram[10'h165], 16'h0601);
        check(mem.ram[10'h185], 16'h0602);
        @(posedge clk);
        rx(7'h01, 8'h5A, 1'b0);
        rx_valid <= 1'b0;
        settle();
        check(mem.ram[10'h124], 16'h0402);
        // identity is the control word address field, base bits included
        host(1'b1, 1'b1, 16'hFFFF, 16'h2120);
        check({15'h0000, done_q}, 16'h0001);
        host(1'b1, 1'b1, 16'hFFFF, 16'h1160);
        host(1'b1, 1'b1, 16'hFFFF, 16'h1180);
        check({15'h0000, done_q}, 16'h0000);
        host(1'b1, 1'b0, 16'hF000, 16'h0000);
        for (int s = 1; s < 3; s++) begin
            pcb(10'h104 + 10'(5 * (32 >> s)), 16'h0700, 16'h0700);
            @(posedge clk);
            block_size <= mabs_blk_t'(s);
            rx(7'h05, 8'h33, 1'b1);
            rx_valid <= 1'b0;
            settle();
            host(1'b1, 1'b1, 16'hFFFF, (s == 1) ? 16'h22A0 : 16'h24A0);
        end
        // every byte on port 2 completes its buffer while memory stalls
        pcb(10'h144, 16'h0500, 16'h0500);
        @(posedge clk);
        block_size <= MABS_BLK_32;
        slow <= 1'b1;
        for (int i = 0; i < 45; i++) begin
            bs[i] = 8'($random(seed));
            rx(7'h02, bs[i], 1'b1);
            if (i == 39) begin
                rx_valid <= 1'b0;
                settle();
                host(1'b1, 1'b0, 16'h4000, 16'h0000);
                @(posedge clk);
            end
        end
        rx_valid <= 1'b0;
        settle();
        check(16'(refused > 0), 16'h0001);
        check(mem.ram[10'h144], 16'h052D);
        for (int i = 0; i < 45; i++) begin
            w = mem.ram[10'h280 + 10'((i + 1) >> 1)];
            check({8'h00, (i % 2) ? w[15:8] : w[7:0]}, {8'h00, bs[i]});
        end
        host(1'b1, 1'b0, 16'h4000, 16'h4000);
        host(1'b0, 1'b1, 16'h0000, 16'h0000);
        check({15'h0000, done_q}, 16'h0000);
        host(1'b1, 1'b0, 16'hF000, 16'h0000);
        @(posedge clk);
        rtc_enable <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (!irq_req_q && n < 100);
        end
        check(16'(n), 16'(TICKS));
        @(posedge clk);
        rtc_enable <= 1'b0;
        // a port event queued behind the pending tick shares the word
        rx(7'h02, 8'h77, 1'b1);
        rx_valid <= 1'b0;
        settle();
        host(1'b1, 1'b1, 16'hF000, 16'hA000);
        host(1'b1, 1'b0, 16'h8000, 16'h0000);
        check({15'h0000, done_q}, 16'h0000);
        conclude();
    end
endmodule
